// ### rtl/xint_arb.sv
`default_nettype none

`include "xint_map.svh"

module xint_arb #(
    parameter int N = 8
) (
    input wire logic [N-1:0] req,
    input wire logic [N-1:0] prio_hi,
    output logic valid,
    output logic high,
    output logic [2:0] idx
);
    import xint_pkg::*;

    // ------------------------------------------------------------------
    // two-level fixed-order pick
    // ------------------------------------------------------------------
    // scanning from the last source down lets the lowest index win
    always_comb begin
        logic found_hi;
        logic found_lo;
        logic [2:0] idx_hi;
        logic [2:0] idx_lo;
        found_hi = 1'b0;
        found_lo = 1'b0;
        idx_hi = 3'h0;
        idx_lo = 3'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i] && prio_hi[i]) begin
                found_hi = 1'b1;
                idx_hi = 3'(i);
            end
            if (req[i] && !prio_hi[i]) begin
                found_lo = 1'b1;
                idx_lo = 3'(i);
            end
        end
        valid = found_hi | found_lo;
        high = found_hi;                     // high level beats any low one
        idx = found_hi ? idx_hi : idx_lo;
    end

endmodule // xint_arb

`default_nettype wire

// ### rtl/xint_edge.sv
`default_nettype none

`include "xint_map.svh"

module xint_edge (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic pin_n,
    input wire logic freeze,
    output logic fall
);
    import xint_pkg::*;

    xint_edge_state_s state_reg;
    xint_edge_state_s state_next;

    // ------------------------------------------------------------------
    // falling-edge detect
    // ------------------------------------------------------------------
    // the old level is held while frozen, so a pin that falls during a
    // freeze and stays low is reported once, right after it ends
    always_comb begin
        state_next = state_reg;
        if (!freeze) begin
            state_next.prev = pin_n;
        end
    end

    assign fall = state_reg.prev & ~pin_n & ~freeze;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= '{prev: 1'b1};   // idle line is high
        end else begin
            state_reg <= state_next;
        end
    end

endmodule // xint_edge

`default_nettype wire

// ### rtl/xint_map.svh
`ifndef XINT_MAP_SVH
`define XINT_MAP_SVH

// ----------------------------------------------------------------------
// register byte addresses on the bus
// ----------------------------------------------------------------------
`define XINT_ADDR_CTRL 8'hc0
`define XINT_ADDR_BITOP 8'hc4
`define XINT_ADDR_STATUS 8'hc8
`define XINT_ADDR_MASK 8'hcc
`define XINT_ADDR_SERVE 8'hd0

// ----------------------------------------------------------------------
// field positions of ext_int_control
// ----------------------------------------------------------------------
`define XINT_A_TYPE 0
`define XINT_A_FLAG 1
`define XINT_A_EN 2
`define XINT_A_PRIO 3
`define XINT_B_TYPE 4
`define XINT_B_FLAG 5
`define XINT_B_EN 6
`define XINT_B_PRIO 7

// ----------------------------------------------------------------------
// bit-operation register fields
// ----------------------------------------------------------------------
`define XINT_BITOP_VALUE 8
`define XINT_BITOP_IDX_HI 2

// ----------------------------------------------------------------------
// reset values, source indices, vector layout
// ----------------------------------------------------------------------
`define XINT_CTRL_RESET 8'h00
`define XINT_STATUS_RESET 2'h0
`define XINT_MASK_RESET 2'h0
`define XINT_SRC_A 3'h6
`define XINT_SRC_B 3'h7
`define XINT_VEC_LOW 3'h3
`define XINT_VEC_HIGH 2'h0

`endif

// ### rtl/xint_pkg.sv
`default_nettype none

`include "xint_map.svh"

package xint_pkg;

    // ------------------------------------------------------------------
    // bus data-phase tracking
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        XINT_PH_IDLE = 3'b001,
        XINT_PH_WRITE = 3'b010,
        XINT_PH_READ = 3'b100
    } xint_phase_e;

    // ------------------------------------------------------------------
    // core-side bundles
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [5:0] req;      // ext0, timer0, ext1, timer1, serial, timer2
        logic [5:0] prio_hi;  // same order, 1 = high level
    } xint_core_req_s;

    typedef struct packed {
        logic pending;
        logic high;
        logic [7:0] vector;
    } xint_core_ans_s;

    // ------------------------------------------------------------------
    // module states
    // ------------------------------------------------------------------
    typedef struct packed {
        logic prev;
    } xint_edge_state_s;

    typedef struct packed {
        xint_phase_e phase;
        logic [7:0] wr_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic [7:0] ctrl;
        logic [1:0] status;
        logic [1:0] mask;
        logic irq;
        logic pending;
        logic high;
        logic [2:0] idx;
        logic [7:0] vector;
        logic adv;
        logic adv_done;
    } xint_top_state_s;

    // vector address of a source: eight bytes apart, starting at three
    function automatic logic [7:0] xint_vector(input logic [2:0] idx);
        return {`XINT_VEC_HIGH, idx, `XINT_VEC_LOW};
    endfunction

endpackage : xint_pkg

`default_nettype wire

// ### rtl/xint_top.sv

`default_nettype none

`include "xint_map.svh"

module xint_top #(
    parameter int SOURCES = 8
) (
    input wire logic clock,
    input wire logic arst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // external request pins, active low
    input wire logic ext_irq_a_pin,
    input wire logic ext_irq_b_pin,
    // device type strap and emulation freeze
    input wire logic advanced_type,
    input wire logic emulation_freeze,
    // core side
    input wire xint_pkg::xint_core_req_s core_req,
    input wire logic service_ack,
    output xint_pkg::xint_core_ans_s core_ans,
    // software interrupt
    output logic irq
);
    import xint_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    xint_top_state_s state_reg;
    xint_top_state_s state_next;

    logic [1:0] fall;
    logic [1:0] pins_n;
    logic [SOURCES-1:0] req_all;
    logic [SOURCES-1:0] prio_all;
    logic arb_valid;
    logic arb_high;
    logic [2:0] arb_idx;
    logic addr_take;
    logic [7:0] addr_low;
    logic req_a;
    logic req_b;

    // ------------------------------------------------------------------
    // edge detectors, one per extra pin
    // ------------------------------------------------------------------
    // a pin already low when its type bit turns to edge mode
    // raises no flag until it has gone high and low again
    assign pins_n = {ext_irq_b_pin, ext_irq_a_pin};

    generate
        for (genvar g = 0; g < 2; g++) begin : g_edge
            xint_edge u_edge (
                .clock(clock),
                .arst_n(arst_n),
                .pin_n(pins_n[g]),
                .freeze(emulation_freeze),
                .fall(fall[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // request lines of the two extra sources
    // ------------------------------------------------------------------
    // edge mode takes the latched flag, level mode the live pin;
    // the standard type never raises them
    // a level request drops as soon as its pin is released, so a
    // source that lets go too early is simply not served
    function automatic logic pin_request(
        input logic adv,
        input logic enable,
        input logic edge_mode,
        input logic flag,
        input logic pin_n
    );
        logic r;
        r = 1'b0;
        if (adv && enable) begin
            r = edge_mode ? flag : ~pin_n;
        end
        return r;
    endfunction

    assign req_a = pin_request(state_reg.adv, state_reg.ctrl[`XINT_A_EN],
        state_reg.ctrl[`XINT_A_TYPE], state_reg.ctrl[`XINT_A_FLAG],
        ext_irq_a_pin);
    assign req_b = pin_request(state_reg.adv, state_reg.ctrl[`XINT_B_EN],
        state_reg.ctrl[`XINT_B_TYPE], state_reg.ctrl[`XINT_B_FLAG],
        ext_irq_b_pin);

    // sources in polling order, pin a at six, pin b at seven
    assign req_all = {req_b, req_a, core_req.req};
    assign prio_all = {state_reg.ctrl[`XINT_B_PRIO],
        state_reg.ctrl[`XINT_A_PRIO], core_req.prio_hi};

    // the arbiter is purely combinational; its pick is registered below
    xint_arb #(
        .N(SOURCES)
    ) u_arb (
        .req(req_all),
        .prio_hi(prio_all),
        .valid(arb_valid),
        .high(arb_high),
        .idx(arb_idx)
    );

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    // only the low address byte is decoded, so the map repeats every
    // 256 bytes; a single slave on the bus needs no more
    // map: c0 control, c4 single-bit write (bits 2:0 pick the bit,
    // bit 8 gives its value), c8 sticky events read-cleared,
    // cc event mask, d0 serve view, read only
    // control bits, high to low: b priority, b enable, b flag, b type,
    // then the same four for pin a
    // serve view: bit 0 pending, bit 1 high level, 4:2 source index,
    // 15:8 vector address
    // zero wait states: writes land at the end of the data phase,
    // read data are fetched at the address edge and stand one cycle
    // idle and busy transfers carry htrans[1] low and are ignored
    assign addr_take = hsel & htrans[1] & hready;
    assign addr_low = haddr[7:0];

    // read value of one register; unmapped addresses read as zero
    // the bit-write address is write only and reads as zero too
    function automatic logic [31:0] read_word(input logic [7:0] a,
                                              input xint_top_state_s s);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (a)
            `XINT_ADDR_CTRL: w = {24'h00_0000, s.ctrl};
            `XINT_ADDR_STATUS: w = {30'h0000_0000, s.status};
            `XINT_ADDR_MASK: w = {30'h0000_0000, s.mask};
            `XINT_ADDR_SERVE: w = {16'h0000, s.vector, 3'h0, s.idx,
                                   s.high, s.pending};
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    // bus writes come first, then the service clear, then the
    // hardware set, so an event in the same cycle as either kind
    // of clear is never lost
    always_comb begin
        logic [7:0] c;
        logic [1:0] st;
        logic serviced;
        c = state_reg.ctrl;
        st = state_reg.status;
        serviced = 1'b0;
        state_next = state_reg;

        // the strap is caught once, on the first edge after reset
        // until then both extra sources stay gated off
        if (!state_reg.adv_done) begin
            state_next.adv = advanced_type;
            state_next.adv_done = 1'b1;
        end

        // data phase: writes land here, with hwdata valid
        // a write to an unmapped address is dropped without error
        if (state_reg.phase == XINT_PH_WRITE) begin
            unique case (state_reg.wr_addr)
                `XINT_ADDR_CTRL: c = hwdata[7:0];
                `XINT_ADDR_BITOP: c[hwdata[`XINT_BITOP_IDX_HI:0]] =
                    hwdata[`XINT_BITOP_VALUE];
                `XINT_ADDR_MASK: state_next.mask = hwdata[1:0];
                default: ;
            endcase
        end

        // address phase: latch the write target, or fetch read data
        // the status read clears here, in the address cycle
        state_next.phase = XINT_PH_IDLE;
        if (addr_take) begin
            if (hwrite) begin
                state_next.phase = XINT_PH_WRITE;
                state_next.wr_addr = addr_low;
            end else begin
                state_next.phase = XINT_PH_READ;
                state_next.hrdata = read_word(addr_low, state_reg);
                if (addr_low == `XINT_ADDR_STATUS) begin
                    st = 2'h0;                                      // read clears
                end
            end
        end else if (state_reg.phase != XINT_PH_IDLE) begin
            state_next.hrdata = 32'h0000_0000;
        end

        // servicing the chosen source drops its edge flag
        if (service_ack && state_reg.pending && !emulation_freeze) begin
            serviced = 1'b1;
        end
        if (serviced && state_reg.idx == `XINT_SRC_A && c[`XINT_A_TYPE]) begin
            c[`XINT_A_FLAG] = 1'b0;
        end
        if (serviced && state_reg.idx == `XINT_SRC_B && c[`XINT_B_TYPE]) begin
            c[`XINT_B_FLAG] = 1'b0;
        end

        // hardware set comes last so it wins over any clear
        if (fall[0] && c[`XINT_A_TYPE] && state_reg.adv) begin
            c[`XINT_A_FLAG] = 1'b1;
        end
        if (fall[1] && c[`XINT_B_TYPE] && state_reg.adv) begin
            c[`XINT_B_FLAG] = 1'b1;
        end
        state_next.ctrl = c;

        // sticky events, also set-wins over the read clear
        // every falling edge counts here once the advanced type is strapped, whatever the trigger type
        if (fall[0] && state_reg.adv) begin
            st[0] = 1'b1;
        end
        if (fall[1] && state_reg.adv) begin
            st[1] = 1'b1;
        end
        state_next.status = st;
        state_next.irq = |(st & state_next.mask);

        // the core sees the winner one cycle late; frozen in emulation
        // registering the pick keeps the pins out of the core's
        // vector fetch path, at the price of one cycle of latency
        if (!emulation_freeze) begin
            state_next.pending = arb_valid;
            state_next.high = arb_high;
            state_next.idx = arb_idx;
            state_next.vector = arb_valid ? xint_vector(arb_idx)
                : 8'h00;
        end

        state_next.hreadyout = 1'b1;                                // zero wait states
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // constants only in the reset branch; the control register has
    // no defined power-up value, so every field but phase and hreadyout starts cleared
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_reg.phase <= XINT_PH_IDLE;
            state_reg.wr_addr <= 8'h00;
            state_reg.hrdata <= 32'h0000_0000;
            state_reg.hreadyout <= 1'b1;
            state_reg.ctrl <= `XINT_CTRL_RESET;
            state_reg.status <= `XINT_STATUS_RESET;
            state_reg.mask <= `XINT_MASK_RESET;
            state_reg.irq <= 1'b0;
            state_reg.pending <= 1'b0;
            state_reg.high <= 1'b0;
            state_reg.idx <= 3'h0;
            state_reg.vector <= 8'h00;
            state_reg.adv <= 1'b0;
            state_reg.adv_done <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // outputs, straight from the state register except the constant hresp
    // ------------------------------------------------------------------
    assign hreadyout = state_reg.hreadyout;
    assign hrdata = state_reg.hrdata;
    assign hresp = 1'b0;                 // always okay, constant
    assign core_ans.pending = state_reg.pending;
    assign core_ans.high = state_reg.high;
    assign core_ans.vector = state_reg.vector;
    assign irq = state_reg.irq;

    // hsize is not checked: only whole-word transfers are expected
    // a narrow write would still store the whole low byte
    logic unused_ok;
    assign unused_ok = ^{hsize, haddr[31:8]};

endmodule // xint_top

`default_nettype wire

// ### tb/test_xint_top.sv
`default_nettype none

module test_xint_top;
    timeunit 1ns;
    timeprecision 1ns;
    import xint_pkg::*;

    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic advanced_type = 1'b1;
    logic emulation_freeze = 1'b0;
    logic service_ack = 1'b0;
    xint_core_req_s core_req = '0;
    logic hreadyout, hresp, irq, pa, pb;
    logic [31:0] hrdata, rd;
    xint_core_ans_s core_ans;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;

    // 100 ns period
    always #50 clock = ~clock;

    xint_src src (.clock(clock), .pin_a_n(pa), .pin_b_n(pb));
    xint_top uut (.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ext_irq_a_pin(pa),
        .ext_irq_b_pin(pb), .advanced_type(advanced_type), .emulation_freeze(emulation_freeze),
        .core_req(core_req), .service_ack(service_ack), .core_ans(core_ans), .irq(irq));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // single word transfer; entered just after an edge so requests may run back to back
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0000_0000);
        chk(what, rd, exp);
    endtask

    // a hang ends in the same closing report
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            close_out();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        repeat (2) @(posedge clock);
        rdchk("ctrl reset", 8'hc0, 32'h0000_0000);
        rdchk("status reset", 8'hc8, 32'h0000_0000);
        rdchk("mask reset", 8'hcc, 32'h0000_0000);
        wr(8'he0, 32'h0000_00ff);
        rdchk("unmapped", 8'he0, 32'h0000_0000);
        wr(8'hc0, 32'h0000_00a5);
        rdchk("ctrl rw", 8'hc0, 32'h0000_00a5);
        wr(8'hc0, 32'h0000_0000);
        wr(8'hc4, 32'h0000_0102);
        rdchk("bit set", 8'hc0, 32'h0000_0004);
        $display("test registers done");
        // level mode on pin a: request follows the pin, flag never latches
        src.drive(1'b0, 1'b0);
        repeat (3) @(posedge clock);
        rdchk("level a serve", 8'hd0, 32'h0000_3319);
        rdchk("level a no flag", 8'hc0, 32'h0000_0004);
        src.drive(1'b0, 1'b1);
        repeat (3) @(posedge clock);
        ahb(1'b0, 8'hd0, 32'h0000_0000);
        chk("level a gone", {31'h0, rd[0]}, 32'h0000_0000);
        rdchk("level a event", 8'hc8, 32'h0000_0001);
        $display("test level done");
        // edge mode on pin b: flag set, serviced, sticky status read-cleared
        wr(8'hcc, 32'h0000_0002);
        wr(8'hc0, 32'h0000_0050);
        src.pulse(1'b1);
        repeat (2) @(posedge clock);
        chk("irq b", {31'h0, irq}, 32'h0000_0001);
        rdchk("flag b set", 8'hc0, 32'h0000_0070);
        rdchk("edge b serve", 8'hd0, 32'h0000_3b1d);
        chk("core vector b", {24'h00_0000, core_ans.vector}, 32'h0000_003b);
        service_ack <= 1'b1;
        @(posedge clock);
        service_ack <= 1'b0;
        @(posedge clock);
        rdchk("flag b cleared", 8'hc0, 32'h0000_0050);
        rdchk("status b", 8'hc8, 32'h0000_0002);
        repeat (2) @(posedge clock);
        chk("irq b cleared", {31'h0, irq}, 32'h0000_0000);
        rdchk("status cleared", 8'hc8, 32'h0000_0000);
        $display("test edge done");
        // priority level, then polling order over every source
        wr(8'hc0, 32'h0000_00c4);
        src.drive(1'b0, 1'b0);
        src.drive(1'b1, 1'b0);
        core_req.req <= 6'h01;
        repeat (3) @(posedge clock);
        rdchk("b high wins", 8'hd0, 32'h0000_3b1f);
        wr(8'hc0, 32'h0000_0044);
        for (int i = 0; i < 6; i++) begin
            core_req.req <= 6'(1 << i);
            repeat (3) @(posedge clock);
            rdchk("core order", 8'hd0, {16'h0000, 8'(8 * i + 3), 3'h0, 3'(i), 2'h1});
        end
        core_req.req <= 6'h00;
        repeat (3) @(posedge clock);
        rdchk("a before b", 8'hd0, 32'h0000_3319);
        wr(8'hc0, 32'h0000_0000);
        repeat (3) @(posedge clock);
        ahb(1'b0, 8'hd0, 32'h0000_0000);
        chk("both blocked", {31'h0, rd[0]}, 32'h0000_0000);
        src.drive(1'b0, 1'b1);
        src.drive(1'b1, 1'b1);
        rdchk("both events", 8'hc8, 32'h0000_0003);
        $display("test priority done");
        // freeze holds detection, the edge is taken once after release
        wr(8'hcc, 32'h0000_0001);
        wr(8'hc0, 32'h0000_0005);
        emulation_freeze <= 1'b1;
        src.drive(1'b0, 1'b0);
        repeat (3) @(posedge clock);
        rdchk("frozen flag", 8'hc0, 32'h0000_0005);
        chk("frozen irq", {31'h0, irq}, 32'h0000_0000);
        emulation_freeze <= 1'b0;
        repeat (3) @(posedge clock);
        rdchk("released flag", 8'hc0, 32'h0000_0007);
        chk("released irq", {31'h0, irq}, 32'h0000_0001);
        src.drive(1'b0, 1'b1);
        wr(8'hcc, 32'h0000_0000);
        repeat (2) @(posedge clock);
        chk("masked irq", {31'h0, irq}, 32'h0000_0000);
        rdchk("status a", 8'hc8, 32'h0000_0001);
        $display("test freeze done");
        close_out();
    end
endmodule // test_xint_top

`default_nettype wire

// ### tb/xint_src.sv
`default_nettype none

module xint_src (
    input wire logic clock,
    output var logic pin_a_n,
    output var logic pin_b_n
);
    timeunit 1ns;
    timeprecision 1ns;

    // both request lines idle high, requests are active low
    initial begin
        pin_a_n = 1'b1;
        pin_b_n = 1'b1;
    end

    // called just after a rising edge, so the change lands off the sampling point
    task automatic drive(input logic sel, input logic lvl);
        if (sel) pin_b_n <= lvl;
        else pin_a_n <= lvl;
    endtask

    // one falling edge, low for two edges, then released
    task automatic pulse(input logic sel);
        drive(sel, 1'b0);
        repeat (2) @(posedge clock);
        drive(sel, 1'b1);
        @(posedge clock);
    endtask
endmodule // xint_src

`default_nettype wire

// ### tb/xint_sva.sv
`default_nettype none

`include "xint_map.svh"

module xint_sva
    import xint_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic ext_irq_a_pin,
    input wire logic ext_irq_b_pin,
    input wire logic advanced_type,
    input wire logic emulation_freeze,
    input wire xint_pkg::xint_core_req_s core_req,
    input wire xint_pkg::xint_core_ans_s core_ans,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic wr_reg;
    logic [7:0] adr_reg;
    logic [7:0] ctl_reg;
    logic [1:0] msk_reg;

    // mirror of software-owned control bits; flags are left to hardware, so never read here
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wr_reg <= 1'b0;
            adr_reg <= 8'h00;
            ctl_reg <= 8'h00;
            msk_reg <= 2'h0;
        end else begin
            wr_reg <= hsel && htrans[1] && hready && hwrite;
            adr_reg <= haddr[7:0];
            if (wr_reg && adr_reg == `XINT_ADDR_CTRL) ctl_reg <= hwdata[7:0];
            if (wr_reg && adr_reg == `XINT_ADDR_BITOP) ctl_reg[hwdata[2:0]] <= hwdata[8];
            if (wr_reg && adr_reg == `XINT_ADDR_MASK) msk_reg <= hwdata[1:0];
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    AST_OKAY: assert property (hresp == 1'b0) else $error("response not okay");
    AST_READY: assert property (hreadyout == 1'b1) else $error("wait state seen");
    AST_VECTOR: assert property (core_ans.pending |->
        core_ans.vector[2:0] == 3'h3 && core_ans.vector[7:6] == 2'h0)
        else $error("vector off the eight-byte grid");
    AST_LEVEL_A: assert property ((advanced_type && !emulation_freeze && core_req.req == 6'h00
        && ext_irq_b_pin && !ext_irq_a_pin && ctl_reg[2] && !ctl_reg[0] && !ctl_reg[6])[*2]
        |-> core_ans.pending && core_ans.vector == 8'h33) else $error("level request lost");
    AST_EDGE_IRQ: assert property ($fell(ext_irq_a_pin) && advanced_type
        && !emulation_freeze && msk_reg[0] |-> ##[0:1] irq) else $error("event did not raise irq");
    AST_ORDER: assert property ((core_req.req[0] && core_req.prio_hi == 6'h00
        && !ctl_reg[3] && !ctl_reg[7] && !emulation_freeze)[*2]
        |-> core_ans.pending && core_ans.vector == 8'h03) else $error("ext0 not served first");
    AST_PRIO_B: assert property ((advanced_type && !emulation_freeze && !ext_irq_b_pin
        && ctl_reg[6] && ctl_reg[7] && !ctl_reg[4] && !ctl_reg[3] && core_req.prio_hi == 6'h00)[*2]
        |-> core_ans.high && core_ans.vector == 8'h3b) else $error("high level of b ignored");
    AST_BLOCK: assert property ((core_req.req == 6'h00 && !ctl_reg[2] && !ctl_reg[6]
        && !emulation_freeze)[*2] |-> !core_ans.pending) else $error("disabled source pending");
    AST_FREEZE: assert property ($past(emulation_freeze) |-> $stable(core_ans))
        else $error("answer moved while frozen");

    // main scenarios reached
    COV_IRQ: cover property (irq);
    COV_HIGH: cover property (core_ans.pending && core_ans.high);
    COV_FROZEN: cover property (emulation_freeze && ext_irq_a_pin == 1'b0);
endmodule // xint_sva

bind xint_top xint_sva u_sva (.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .ext_irq_a_pin(ext_irq_a_pin),
    .ext_irq_b_pin(ext_irq_b_pin), .advanced_type(advanced_type),
    .emulation_freeze(emulation_freeze), .core_req(core_req), .core_ans(core_ans), .irq(irq));

`default_nettype wire
